// ==== rtl/standby_cable_energy_indicator_control_regs.sv ====
// standby, signal-detect, termination, symbol-error counter and filter-disable registers
// assumes mgmt requests are single-cycle strobes on REF_CLK; energy and error pins are async
//
// Contract
// - software method: manual sleep bit 1 enters standby, 0 stays normal
// - standby left only by hardware reset, never by clearing bits
// - nv access bit enables retained copy of standby reg and 13h bits 9:8,1:0
// - enable 1: permit standby, indicator tracks energy; 0: indicator forced true
// - rx termination off bit disables receive termination only
// - delay select picks minimum or increased delay before indicator deasserts
// - automatic method waits same delay before powering into standby
// - polarity bit 1 makes indicator active low; default active high
// - 16-bit error frame counter, zero at reset, clears on read
// - filter disable sets on write 1, write 0 ignored, reset from strap
// - method bit 1 software control, 0 automatic on no cable energy
`timescale 1ns/100ps
`default_nettype none
module standby_cable_energy_indicator_control_regs
   import sbsd_pkg::*;
#(
   parameter int LONG_DELAY_CYC = DELAY_LONG_CYC
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST_B,
   input  wire mgmt_req_s   MGMT_REQ,
   output var  logic [15:0] MGMT_RDATA,
   output var  logic        MGMT_RVALID,
   input  wire logic        CABLE_ENERGY,
   input  wire logic        SYMBOL_ERROR_FRAME,
   input  wire logic        RECEIVE_ERROR_PIN,
   output var  logic        CABLE_ENERGY_INDICATOR,
   output var  logic        STANDBY_POWER_DOWN,
   output var  logic        RX_TERM_DISABLE,
   output var  logic        EMISSION_FILTER_ENABLE,
   output var  logic        NV_COPY_ENABLE,
   output var  logic [15:0] NV_COPY_STANDBY,
   output var  logic [3:0]  NV_COPY_AFE2
);
   logic [2:0]  sync_reg, sync_next;
   logic [15:0] standby_reg, standby_next;
   logic [15:0] opmode_reg, opmode_next;
   logic [15:0] afe2_reg, afe2_next;
   logic [15:0] count_reg, count_next;
   logic [1:0]  strap_cnt_reg, strap_cnt_next;
   logic        strap_done_reg, strap_done_next;
   logic [31:0] delay_reg, delay_next;
   logic        energy_seen_reg, energy_seen_next;
   logic        err_last_reg, err_last_next;
   pwr_state_e  pwr_reg, pwr_next;
   logic [15:0] rdata_reg, rdata_next;
   logic        rvalid_reg, rvalid_next;
   logic        ind_next;
   logic        energy_s, err_s, strap_s, err_rise;
   logic [31:0] delay_target;
   logic        strap_take;
   logic        pdown_next, term_off_next, filter_en_next, nv_en_next;
   logic [15:0] nv_std_next;
   logic [3:0]  nv_afe2_next;

   // two flops for each async pin: [0] energy, [1] error, [2] strap
   logic [2:0] meta_reg;
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         meta_reg <= 3'h0;
         sync_reg <= 3'h0;
      end else begin
         meta_reg <= {RECEIVE_ERROR_PIN, SYMBOL_ERROR_FRAME, CABLE_ENERGY};
         sync_reg <= sync_next;
      end
   end
   always_comb begin
      sync_next = meta_reg;
   end
   assign energy_s = sync_reg[0];
   assign err_s    = sync_reg[1];
   assign strap_s  = sync_reg[2];
   assign err_rise = err_s & ~err_last_reg;
   assign delay_target = standby_reg[POS_DELAY_SEL] ? 32'(LONG_DELAY_CYC)
                                                     : 32'(DELAY_MIN_CYC);

   // strap caught a few clocks after release, once the sync chain holds it
   always_comb begin
      strap_cnt_next  = strap_cnt_reg;
      strap_done_next = strap_done_reg;
      strap_take      = 1'b0;
      if (!strap_done_reg) begin
         if (strap_cnt_reg == 2'(STRAP_WAIT_CYC)) begin
            strap_done_next = 1'b1;
            strap_take      = 1'b1;
         end else begin
            strap_cnt_next = strap_cnt_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         strap_cnt_reg  <= 2'h0;
         strap_done_reg <= 1'b0;
      end else begin
         strap_cnt_reg  <= strap_cnt_next;
         strap_done_reg <= strap_done_next;
      end
   end

   always_comb begin
      standby_next     = standby_reg;
      opmode_next      = opmode_reg;
      afe2_next        = afe2_reg;
      count_next       = count_reg;
      err_last_next    = err_s;
      rdata_next       = rdata_reg;
      rvalid_next      = 1'b0;
      // a write to the mode register before this may be overwritten
      if (strap_take) begin
         opmode_next[POS_FILTER_OFF] = strap_s;
      end
      // counter: an error frame in the read cycle survives as the new count
      if (err_rise && count_reg != COUNT_MAX) begin
         count_next = count_reg + 16'h0001;
      end
      if (MGMT_REQ.read) begin
         rvalid_next = 1'b1;
         if (MGMT_REQ.addr == ADDR_STANDBY_CTRL) begin
            rdata_next = standby_reg;
         end else if (MGMT_REQ.addr == ADDR_SYMERR_COUNT) begin
            rdata_next = count_reg;
            count_next = err_rise ? 16'h0001 : RESET_WORD;
         end else if (MGMT_REQ.addr == ADDR_OPMODE_CTRL) begin
            rdata_next = opmode_reg;
         end else if (MGMT_REQ.addr == ADDR_AFE_CTRL2) begin
            rdata_next = afe2_reg;
         end else begin
            rdata_next = RESET_WORD;
         end
      end else if (MGMT_REQ.write) begin
         if (MGMT_REQ.addr == ADDR_STANDBY_CTRL) begin
            standby_next = MGMT_REQ.wdata & STANDBY_CTRL_MASK;
         end else if (MGMT_REQ.addr == ADDR_OPMODE_CTRL) begin
            opmode_next = (MGMT_REQ.wdata & OPMODE_MASK)
                        | (opmode_reg & ~OPMODE_MASK)
                        | (MGMT_REQ.wdata & ~OPMODE_MASK);
         end else if (MGMT_REQ.addr == ADDR_AFE_CTRL2) begin
            afe2_next = MGMT_REQ.wdata & AFE2_NV_MASK;
         end
      end
   end

   // signal-detect deassertion delay; counter parks at the target
   always_comb begin
      delay_next       = delay_reg;
      energy_seen_next = energy_seen_reg;
      if (energy_s) begin
         delay_next       = 32'h0;
         energy_seen_next = 1'b1;
      end else if (delay_reg < delay_target) begin
         delay_next = delay_reg + 32'h1;
      end else begin
         energy_seen_next = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         delay_reg       <= 32'h0;
         energy_seen_reg <= 1'b0;
      end else begin
         delay_reg       <= delay_next;
         energy_seen_reg <= energy_seen_next;
      end
   end

   // standby sequencing; sleep is a trap state left only by reset
   always_comb begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         PWR_NORMAL: begin
            if (standby_reg[POS_STANDBY_EN]) begin
               if (standby_reg[POS_SLEEP_METHOD]) begin
                  if (standby_reg[POS_MANUAL_SLEEP]) begin
                     pwr_next = PWR_SLEEP;
                  end
               end else if (!energy_s) begin
                  pwr_next = PWR_DRAIN;
               end
            end
         end
         PWR_DRAIN: begin
            if (energy_s || !standby_reg[POS_STANDBY_EN] || standby_reg[POS_SLEEP_METHOD]) begin
               pwr_next = PWR_NORMAL;
            end else if (!energy_seen_next) begin
               pwr_next = PWR_SLEEP;
            end
         end
         PWR_SLEEP: begin
            pwr_next = PWR_SLEEP;
         end
         default: begin
            pwr_next = PWR_NORMAL;
         end
      endcase
      // forced true when disabled, else delayed energy, then polarity
      ind_next = (standby_reg[POS_STANDBY_EN] ? energy_seen_next : 1'b1)
               ^ standby_reg[POS_POLARITY];
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pwr_reg <= PWR_NORMAL;
      end else begin
         pwr_reg <= pwr_next;
      end
   end

   // register file and counter group
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         standby_reg  <= RESET_WORD;
         opmode_reg   <= RESET_WORD;
         afe2_reg     <= RESET_WORD;
         count_reg    <= RESET_WORD;
         err_last_reg <= 1'b0;
         rdata_reg    <= RESET_WORD;
         rvalid_reg   <= 1'b0;
      end else begin
         standby_reg  <= standby_next;
         opmode_reg   <= opmode_next;
         afe2_reg     <= afe2_next;
         count_reg    <= count_next;
         err_last_reg <= err_last_next;
         rdata_reg    <= rdata_next;
         rvalid_reg   <= rvalid_next;
      end
   end

   // pin images taken from next values so register writes show one cycle later; power down and indicator show two cycles later
   always_comb begin
      pdown_next     = (pwr_next == PWR_SLEEP);
      term_off_next  = standby_next[POS_RX_TERM_OFF];
      filter_en_next = ~opmode_next[POS_FILTER_OFF];
      nv_en_next     = standby_next[POS_NV_ACCESS];
      nv_std_next    = 16'h0000;
      nv_afe2_next   = 4'h0;
      // retained copy hidden unless access is enabled
      if (standby_next[POS_NV_ACCESS]) begin
         nv_std_next  = standby_next;
         nv_afe2_next = {afe2_next[9:8], afe2_next[1:0]};
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         CABLE_ENERGY_INDICATOR <= 1'b1;
         STANDBY_POWER_DOWN     <= 1'b0;
         RX_TERM_DISABLE        <= 1'b0;
         EMISSION_FILTER_ENABLE <= 1'b1;
         NV_COPY_ENABLE         <= 1'b0;
         NV_COPY_STANDBY        <= 16'h0000;
         NV_COPY_AFE2           <= 4'h0;
      end else begin
         CABLE_ENERGY_INDICATOR <= ind_next;
         STANDBY_POWER_DOWN     <= pdown_next;
         RX_TERM_DISABLE        <= term_off_next;
         EMISSION_FILTER_ENABLE <= filter_en_next;
         NV_COPY_ENABLE         <= nv_en_next;
         NV_COPY_STANDBY        <= nv_std_next;
         NV_COPY_AFE2           <= nv_afe2_next;
      end
   end

   assign MGMT_RDATA  = rdata_reg;
   assign MGMT_RVALID = rvalid_reg;
endmodule
`default_nettype wire

// ==== common/sbsd_pkg.sv ====
// package for the standby and signal-detect control register bank
// assumes a management access port on the device reference clock
package sbsd_pkg;
   localparam logic [4:0]  ADDR_STANDBY_CTRL  = 5'h14;
   localparam logic [4:0]  ADDR_SYMERR_COUNT  = 5'h15;
   localparam logic [4:0]  ADDR_OPMODE_CTRL   = 5'h16;
   localparam logic [4:0]  ADDR_AFE_CTRL2     = 5'h13;
   localparam int          POS_POLARITY       = 0;
   localparam int          POS_DELAY_SEL      = 1;
   localparam int          POS_RX_TERM_OFF    = 2;
   localparam int          POS_STANDBY_EN     = 3;
   localparam int          POS_NV_ACCESS      = 4;
   localparam int          POS_MANUAL_SLEEP   = 5;
   localparam int          POS_SLEEP_METHOD   = 6;
   localparam int          POS_FILTER_OFF     = 12;
   localparam logic [15:0] STANDBY_CTRL_MASK  = 16'h007f;
   localparam logic [15:0] AFE2_NV_MASK       = 16'h0303;
   localparam logic [15:0] OPMODE_MASK        = 16'hefff;
   localparam logic [15:0] RESET_WORD         = 16'h0000;
   localparam logic [15:0] COUNT_MAX          = 16'hffff;
   localparam int          REF_CLK_MHZ        = 50;
   localparam int          DELAY_MIN_US       = 1;
   localparam int          DELAY_LONG_US      = 256;
   localparam int          DELAY_MIN_CYC      = DELAY_MIN_US * REF_CLK_MHZ;
   localparam int          DELAY_LONG_CYC     = DELAY_LONG_US * REF_CLK_MHZ;
   localparam int          STRAP_WAIT_CYC     = 3;

   typedef enum logic [1:0] {
      PWR_NORMAL,
      PWR_DRAIN,
      PWR_SLEEP
   } pwr_state_e;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [4:0] addr;
      logic [15:0] wdata;
   } mgmt_req_s;
endpackage

// ==== verif/standby_cable_energy_indicator_chk.sv ====
// port assertions for the standby and signal-detect register bank
// assumes it is bound onto the top module; one clock domain
`timescale 1ns/100ps
`default_nettype none
module standby_cable_energy_indicator_chk
   import sbsd_pkg::*;
(
   input wire logic        REF_CLK,
   input wire logic        RST_B,
   input wire mgmt_req_s   MGMT_REQ,
   input wire logic        MGMT_RVALID,
   input wire logic        CABLE_ENERGY,
   input wire logic        CABLE_ENERGY_INDICATOR,
   input wire logic        STANDBY_POWER_DOWN,
   input wire logic        RX_TERM_DISABLE,
   input wire logic        EMISSION_FILTER_ENABLE,
   input wire logic        NV_COPY_ENABLE,
   input wire logic [15:0] NV_COPY_STANDBY,
   input wire logic [3:0]  NV_COPY_AFE2
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   logic wr14;
   assign wr14 = MGMT_REQ.write && !MGMT_REQ.read && MGMT_REQ.addr == ADDR_STANDBY_CTRL;
   read_strobe_a: assert property (MGMT_REQ.read |=> MGMT_RVALID)
      else $error("read not answered");
   strobe_only_a: assert property (!MGMT_REQ.read |=> !MGMT_RVALID)
      else $error("data strobe without read");
   sleep_entry_a: assert property (wr14 && MGMT_REQ.wdata[6] && MGMT_REQ.wdata[5] && MGMT_REQ.wdata[3] |=> ##1 STANDBY_POWER_DOWN)
      else $error("manual sleep not entered");
   sleep_held_a: assert property (STANDBY_POWER_DOWN && !CABLE_ENERGY ##1 !CABLE_ENERGY |-> STANDBY_POWER_DOWN)
      else $error("standby left without reset");
   term_follow_a: assert property (wr14 |=> RX_TERM_DISABLE == $past(MGMT_REQ.wdata[2]))
      else $error("termination disable wrong");
   forced_true_a: assert property (wr14 && !MGMT_REQ.wdata[3] && !STANDBY_POWER_DOWN |=> ##1 CABLE_ENERGY_INDICATOR != $past(MGMT_REQ.wdata[0], 2))
      else $error("indicator not forced true");
   filter_oneway_a: assert property (!$rose(EMISSION_FILTER_ENABLE))
      else $error("filter re-enabled");
   nv_gate_a: assert property (!NV_COPY_ENABLE |-> NV_COPY_STANDBY == 16'h0000 && NV_COPY_AFE2 == 4'h0)
      else $error("retained copy visible while disabled");
   min_delay_a: assert property ($fell(CABLE_ENERGY) && !STANDBY_POWER_DOWN |=> !STANDBY_POWER_DOWN [*8])
      else $error("power down before delay");
   cover property ($rose(STANDBY_POWER_DOWN));
   cover property ($fell(EMISSION_FILTER_ENABLE));
   cover property (MGMT_RVALID && NV_COPY_ENABLE);
endmodule
`default_nettype wire

// ==== verif/standby_cable_energy_indicator_control_regs_tb.sv ====
// self-checking bench for the standby and signal-detect register bank
// assumes package, design and checker are compiled before it
`timescale 1ns/100ps
`default_nettype none
module standby_cable_energy_indicator_control_regs_tb;
   import sbsd_pkg::*;
   localparam int LONG = 20;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   mgmt_req_s   req = '0;
   logic        energy = 1'b1;
   logic        err_frame = 1'b0;
   logic        strap = 1'b0;
   logic [15:0] rdata, nv_std;
   logic [3:0]  nv_afe2;
   logic        rvalid, ind, pdown, term_off, filt_en, nv_en;
   int          n_errors = 0;
   int          comparisons = 0;
   always #10 ref_clk = ~ref_clk;
   standby_cable_energy_indicator_control_regs #(.LONG_DELAY_CYC(LONG)) DUT (.REF_CLK(ref_clk), .RST_B(rst_b),
      .MGMT_REQ(req), .MGMT_RDATA(rdata), .MGMT_RVALID(rvalid), .CABLE_ENERGY(energy),
      .SYMBOL_ERROR_FRAME(err_frame), .RECEIVE_ERROR_PIN(strap), .CABLE_ENERGY_INDICATOR(ind),
      .STANDBY_POWER_DOWN(pdown), .RX_TERM_DISABLE(term_off), .EMISSION_FILTER_ENABLE(filt_en),
      .NV_COPY_ENABLE(nv_en), .NV_COPY_STANDBY(nv_std), .NV_COPY_AFE2(nv_afe2));
   task automatic stop_test;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic do_reset(input logic s);
      strap = s;
      rst_b = 1'b0;
      repeat (8) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (8) @(negedge ref_clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      req = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
      @(negedge ref_clk);
      req = '0;
      @(negedge ref_clk);
   endtask
   // rvalid stands one cycle only, so it is looked at right after the taking edge
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      req = '{write: 1'b0, read: 1'b1, addr: a, wdata: 16'h0000};
      @(negedge ref_clk);
      req = '0;
      chk({15'h0000, rvalid}, 16'h0001);
      chk(rdata, exp);
      @(negedge ref_clk);
   endtask
   task automatic t_reset_values;
      rd(ADDR_STANDBY_CTRL, RESET_WORD);
      rd(ADDR_SYMERR_COUNT, RESET_WORD);
      chk({14'h0000, ind, pdown}, 16'h0002);
      wr(ADDR_OPMODE_CTRL, 16'h1000);
      chk({15'h0000, filt_en}, 16'h0000);
      wr(ADDR_OPMODE_CTRL, 16'h0000);
      chk({15'h0000, filt_en}, 16'h0000);
      rd(ADDR_OPMODE_CTRL, 16'h1000);
      rd(5'h1f, 16'h0000);
   endtask
   task automatic t_ctrl_bits;
      wr(ADDR_STANDBY_CTRL, 16'hff85);
      rd(ADDR_STANDBY_CTRL, 16'h0005);
      chk({14'h0000, term_off, ind}, 16'h0002);
      wr(ADDR_AFE_CTRL2, 16'hffff);
      wr(ADDR_STANDBY_CTRL, 16'h0011);
      chk(nv_std, 16'h0011);
      chk({11'h000, nv_en, nv_afe2}, 16'h001f);
      wr(ADDR_STANDBY_CTRL, 16'h0000);
      chk({nv_afe2, nv_std[11:0]}, 16'h0000);
   endtask
   task automatic t_counter;
      wr(ADDR_SYMERR_COUNT, 16'h00ff);
      repeat (3) begin
         err_frame = 1'b1;
         repeat (2) @(negedge ref_clk);
         err_frame = 1'b0;
         repeat (2) @(negedge ref_clk);
      end
      repeat (3) @(negedge ref_clk);
      rd(ADDR_SYMERR_COUNT, 16'h0003);
      rd(ADDR_SYMERR_COUNT, 16'h0000);
   endtask
   task automatic t_auto(input logic [15:0] ctl, input int lo, input int hi);
      int n;
      do_reset(1'b0);
      energy = 1'b1;
      wr(ADDR_STANDBY_CTRL, ctl);
      repeat (4) @(negedge ref_clk);
      chk({15'h0000, ind}, 16'h0001);
      energy = 1'b0;
      for (n = 0; n < 200 && pdown !== 1'b1; n++) @(negedge ref_clk);
      if (n == 200) begin
         n_errors++;
         stop_test();
      end
      chk(16'(n >= lo && n <= hi), 16'h0001);
      chk({15'h0000, ind}, 16'h0000);
   endtask
   task automatic t_manual;
      do_reset(1'b1);
      chk({15'h0000, filt_en}, 16'h0000);
      wr(ADDR_STANDBY_CTRL, 16'h0058);
      chk({15'h0000, pdown}, 16'h0000);
      wr(ADDR_STANDBY_CTRL, 16'h0078);
      chk({15'h0000, pdown}, 16'h0001);
      wr(ADDR_STANDBY_CTRL, 16'h0000);
      repeat (20) @(negedge ref_clk);
      chk({15'h0000, pdown}, 16'h0001);
      do_reset(1'b0);
      chk({15'h0000, pdown}, 16'h0000);
   endtask
   initial begin
      do_reset(1'b0);
      t_reset_values();
      t_ctrl_bits();
      t_counter();
      t_auto(16'h0018, DELAY_MIN_CYC, DELAY_MIN_CYC + 6);
      t_auto(16'h001a, LONG, LONG + 6);
      t_manual();
      stop_test();
   end
endmodule
bind standby_cable_energy_indicator_control_regs standby_cable_energy_indicator_chk chk_i (.REF_CLK(REF_CLK), .RST_B(RST_B),
   .MGMT_REQ(MGMT_REQ), .MGMT_RVALID(MGMT_RVALID), .CABLE_ENERGY(CABLE_ENERGY),
   .CABLE_ENERGY_INDICATOR(CABLE_ENERGY_INDICATOR), .STANDBY_POWER_DOWN(STANDBY_POWER_DOWN),
   .RX_TERM_DISABLE(RX_TERM_DISABLE), .EMISSION_FILTER_ENABLE(EMISSION_FILTER_ENABLE),
   .NV_COPY_ENABLE(NV_COPY_ENABLE), .NV_COPY_STANDBY(NV_COPY_STANDBY), .NV_COPY_AFE2(NV_COPY_AFE2));
`default_nettype wire
